// [logic/async_serial_comm_unit.sv]
// Asynchronous-mode serial communication unit with double-buffered transmit and receive paths.
`timescale 1ns/100ps
`include "serial_unit_cfg.svh"

module async_serial_comm_unit #(
  parameter int DIV_W = `SU_DIV_WIDTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Format settings
  input wire logic seven_bit,
  input wire logic parity_enable,
  input wire logic parity_odd_sel,
  input wire logic multiproc_enable,
  input wire logic two_stop,
  input wire logic [DIV_W-1:0] baud_div_reg,
  // Control settings
  input wire logic clk_src_hi,
  input wire logic clk_src_lo,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic tx_empty_irq_enable,
  input wire logic tx_done_irq_enable,
  input wire logic rx_irq_enable,
  // Software actions: write and clear pulses of one cycle; multiproc_bit is taken when the shifter loads
  input wire logic tx_holding_wr,
  input wire logic [7:0] tx_holding_wdata,
  input wire logic multiproc_bit,
  input wire logic tx_empty_clr,
  input wire logic rx_full_clr,
  input wire logic parity_error_clr,
  input wire logic framing_error_clr,
  input wire logic overrun_clr,
  // Status
  output logic tx_empty_flag,
  output logic tx_done_flag,
  output logic rx_full_flag,
  output logic parity_error_flag,
  output logic framing_error_flag,
  output logic overrun_flag,
  output logic [7:0] rx_holding_reg,
  output logic rx_multiproc_bit,
  // Interrupt requests, levels
  output logic tx_empty_irq,
  output logic tx_done_irq,
  output logic rx_full_irq,
  output logic rx_err_irq,
  // Serial pins
  input wire logic rx_line,
  output logic tx_line,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe
);

  initial begin
    if (DIV_W < 1 || DIV_W > 16) begin
      $error("async_serial_comm_unit: DIV_W must lie between 1 and 16");
    end
  end

  typedef struct packed {
    serial_unit_pkg::tx_state_e tx_state;
    logic [3:0] tx_phase;
    logic [2:0] tx_cnt;
    logic [7:0] tx_holding;
    logic [7:0] tx_shifter;
    logic tx_mp;
    logic tx_par;
    logic tx_stop2;
    logic tx_pending;
    logic tx_line;
    logic tx_empty_flag;
    logic tx_done_flag;
    logic sck_out;
    logic sck_oe;
    serial_unit_pkg::rx_state_e rx_state;
    logic rx_sync1;
    logic rx_sync2;
    logic [3:0] rx_phase;
    logic [2:0] rx_cnt;
    logic [7:0] rx_shifter;
    logic rx_par;
    logic rx_extra;
    logic [7:0] rx_holding;
    logic rx_mp;
    logic rx_full_flag;
    logic parity_error_flag;
    logic framing_error_flag;
    logic overrun_flag;
    logic tx_empty_irq;
    logic tx_done_irq;
    logic rx_full_irq;
    logic rx_err_irq;
  } unit_s;

  unit_s s;
  unit_s next_s;
  logic tick;

  // Index of the last data bit of a character.
  function automatic logic [2:0] last_bit(input logic seven);
    last_bit = seven ? `SU_LAST_BIT_7 : `SU_LAST_BIT_8;
  endfunction

  // A parity or multiprocessor bit follows the data.
  function automatic logic has_extra(input logic pe, input logic mp);
    has_extra = pe | mp;
  endfunction

  bit_clock_gen #(
    .DIV_W(DIV_W)
  ) u_bit_clock_gen (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ext_sel(clk_src_hi),
    .baud_div_reg(baud_div_reg),
    .sck_in(sck_in),
    .tick(tick)
  );

  always_comb begin
    logic tx_bit_end;
    logic rx_sample;
    logic do_load;
    logic set_done;
    logic rx_err_any;
    logic rx_bit;
    logic perr;
    logic ferr;
    tx_bit_end = 1'b0;
    rx_sample = 1'b0;
    do_load = 1'b0;
    set_done = 1'b0;
    rx_err_any = 1'b0;
    rx_bit = 1'b0;
    perr = 1'b0;
    ferr = 1'b0;
    next_s = s;

    // Transmit side. The phase counter runs freely so the clock output keeps its phase between frames.
    if (tick) begin
      next_s.tx_phase = s.tx_phase + 4'h1;
    end
    tx_bit_end = tick && (s.tx_phase == `SU_LAST_PHASE);
    if (tx_holding_wr) begin
      next_s.tx_holding = tx_holding_wdata;
    end
    if (tx_empty_clr) begin
      next_s.tx_empty_flag = 1'b0;
      next_s.tx_done_flag = 1'b0;
    end

    case (s.tx_state)
      serial_unit_pkg::TX_IDLE: begin
        next_s.tx_line = 1'b1;
        if (tx_bit_end && !s.tx_empty_flag) begin
          do_load = 1'b1;
          next_s.tx_line = 1'b0;
          next_s.tx_state = serial_unit_pkg::TX_START;
        end
      end
      serial_unit_pkg::TX_START: begin
        if (tx_bit_end) begin
          next_s.tx_line = s.tx_shifter[0];
          next_s.tx_par = s.tx_shifter[0];
          next_s.tx_shifter = {1'b0, s.tx_shifter[7:1]};
          next_s.tx_cnt = 3'h0;
          next_s.tx_state = serial_unit_pkg::TX_DATA;
        end
      end
      serial_unit_pkg::TX_DATA: begin
        if (tx_bit_end) begin
          if (s.tx_cnt == last_bit(seven_bit)) begin
            if (has_extra(parity_enable, multiproc_enable)) begin
              // The multiprocessor bit takes the parity slot and parity is then ignored.
              next_s.tx_line = multiproc_enable ? s.tx_mp : (s.tx_par ^ parity_odd_sel);
              next_s.tx_state = serial_unit_pkg::TX_EXTRA;
            end else begin
              next_s.tx_line = 1'b1;
              next_s.tx_stop2 = 1'b0;
              next_s.tx_state = serial_unit_pkg::TX_STOP;
              do_load = !s.tx_empty_flag;
              set_done = s.tx_empty_flag;
            end
          end else begin
            next_s.tx_line = s.tx_shifter[0];
            next_s.tx_par = s.tx_par ^ s.tx_shifter[0];
            next_s.tx_shifter = {1'b0, s.tx_shifter[7:1]};
            next_s.tx_cnt = s.tx_cnt + 3'h1;
          end
        end
      end
      serial_unit_pkg::TX_EXTRA: begin
        if (tx_bit_end) begin
          next_s.tx_line = 1'b1;
          next_s.tx_stop2 = 1'b0;
          next_s.tx_state = serial_unit_pkg::TX_STOP;
          do_load = !s.tx_empty_flag;
          set_done = s.tx_empty_flag;
        end
      end
      serial_unit_pkg::TX_STOP: begin
        if (tx_bit_end) begin
          if (two_stop && !s.tx_stop2) begin
            next_s.tx_stop2 = 1'b1;
          end else if (s.tx_pending) begin
            next_s.tx_pending = 1'b0;
            next_s.tx_line = 1'b0;
            next_s.tx_state = serial_unit_pkg::TX_START;
          end else begin
            next_s.tx_state = serial_unit_pkg::TX_IDLE;
          end
        end
      end
      default: begin
        next_s.tx_state = serial_unit_pkg::TX_IDLE;
      end
    endcase

    // Hardware sets are applied last so they win over a software clear in the same cycle.
    if (do_load) begin
      next_s.tx_shifter = s.tx_holding;
      next_s.tx_mp = multiproc_bit;
      next_s.tx_empty_flag = 1'b1;
      next_s.tx_pending = (s.tx_state != serial_unit_pkg::TX_IDLE);
    end
    if (set_done) begin
      next_s.tx_done_flag = 1'b1;
    end

    if (!tx_enable) begin
      next_s.tx_state = serial_unit_pkg::TX_IDLE;
      next_s.tx_shifter = 8'h00;
      next_s.tx_empty_flag = 1'b1;
      next_s.tx_pending = 1'b0;
      next_s.tx_line = 1'b1;
    end

    // Bit-rate clock output, high over the second half of each bit.
    next_s.sck_oe = !clk_src_hi && clk_src_lo;
    next_s.sck_out = next_s.sck_oe && next_s.tx_phase[`SU_SCK_HIGH_BIT];

    // Receive side. The first synchroniser stage feeds only the second.
    next_s.rx_sync1 = rx_line;
    next_s.rx_sync2 = s.rx_sync1;
    rx_bit = s.rx_sync2;
    rx_err_any = s.overrun_flag || s.framing_error_flag || s.parity_error_flag;
    if (tick) begin
      next_s.rx_phase = s.rx_phase + 4'h1;
    end
    // No sample is taken while disabled, so a frame ending on that edge cannot touch the flags.
    rx_sample = tick && rx_enable && (s.rx_phase == `SU_SAMPLE_PHASE);

    if (rx_full_clr) begin
      next_s.rx_full_flag = 1'b0;
    end
    if (parity_error_clr) begin
      next_s.parity_error_flag = 1'b0;
    end
    if (framing_error_clr) begin
      next_s.framing_error_flag = 1'b0;
    end
    if (overrun_clr) begin
      next_s.overrun_flag = 1'b0;
    end

    case (s.rx_state)
      serial_unit_pkg::RX_IDLE: begin
        // A pending error keeps the receiver from starting a new frame.
        if (tick && !rx_bit && !rx_err_any) begin
          next_s.rx_phase = 4'h0;
          next_s.rx_state = serial_unit_pkg::RX_START;
        end
      end
      serial_unit_pkg::RX_START: begin
        if (rx_sample) begin
          // A start bit that is high again at its centre was a glitch.
          next_s.rx_state = rx_bit ? serial_unit_pkg::RX_IDLE : serial_unit_pkg::RX_DATA;
          next_s.rx_cnt = 3'h0;
          next_s.rx_par = 1'b0;
          next_s.rx_shifter = 8'h00;
        end
      end
      serial_unit_pkg::RX_DATA: begin
        if (rx_sample) begin
          next_s.rx_shifter = {rx_bit, s.rx_shifter[7:1]};
          next_s.rx_par = s.rx_par ^ rx_bit;
          next_s.rx_cnt = s.rx_cnt + 3'h1;
          if (s.rx_cnt == last_bit(seven_bit)) begin
            next_s.rx_state = has_extra(parity_enable, multiproc_enable) ?
                              serial_unit_pkg::RX_EXTRA : serial_unit_pkg::RX_STOP;
          end
        end
      end
      serial_unit_pkg::RX_EXTRA: begin
        if (rx_sample) begin
          next_s.rx_extra = rx_bit;
          next_s.rx_state = serial_unit_pkg::RX_STOP;
        end
      end
      serial_unit_pkg::RX_STOP: begin
        if (rx_sample) begin
          next_s.rx_state = serial_unit_pkg::RX_IDLE;
          perr = parity_enable && !multiproc_enable && ((s.rx_par ^ s.rx_extra) != parity_odd_sel);
          ferr = !rx_bit;
          if (s.rx_full_flag) begin
            next_s.overrun_flag = 1'b1;
          end else begin
            next_s.rx_holding = seven_bit ? {1'b0, s.rx_shifter[7:1]} : s.rx_shifter;
            next_s.rx_mp = s.rx_extra;
            if (!perr && !ferr) begin
              next_s.rx_full_flag = 1'b1;
            end
          end
          if (perr) begin
            next_s.parity_error_flag = 1'b1;
          end
          if (ferr) begin
            next_s.framing_error_flag = 1'b1;
          end
        end
      end
      default: begin
        next_s.rx_state = serial_unit_pkg::RX_IDLE;
      end
    endcase

    // Disabling the receiver drops the frame in progress but leaves flags and data alone.
    if (!rx_enable) begin
      next_s.rx_state = serial_unit_pkg::RX_IDLE;
    end

    // Interrupt requests are levels that follow flag and enable; the transmit-empty request is also gated by tx_enable.
    next_s.tx_empty_irq = tx_enable && next_s.tx_empty_flag && tx_empty_irq_enable;
    next_s.tx_done_irq = next_s.tx_done_flag && tx_done_irq_enable;
    next_s.rx_full_irq = next_s.rx_full_flag && rx_irq_enable;
    next_s.rx_err_irq = (next_s.overrun_flag || next_s.framing_error_flag || next_s.parity_error_flag)
                        && rx_irq_enable;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s <= '0;
      s.tx_state <= serial_unit_pkg::TX_IDLE;
      s.rx_state <= serial_unit_pkg::RX_IDLE;
      s.tx_line <= 1'b1;
      s.tx_empty_flag <= 1'b1;
      s.tx_done_flag <= 1'b1;
      s.rx_sync1 <= 1'b1;
      s.rx_sync2 <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign tx_empty_flag = s.tx_empty_flag;
  assign tx_done_flag = s.tx_done_flag;
  assign rx_full_flag = s.rx_full_flag;
  assign parity_error_flag = s.parity_error_flag;
  assign framing_error_flag = s.framing_error_flag;
  assign overrun_flag = s.overrun_flag;
  assign rx_holding_reg = s.rx_holding;
  assign rx_multiproc_bit = s.rx_mp;
  assign tx_empty_irq = s.tx_empty_irq;
  assign tx_done_irq = s.tx_done_irq;
  assign rx_full_irq = s.rx_full_irq;
  assign rx_err_irq = s.rx_err_irq;
  assign tx_line = s.tx_line;
  assign sck_out = s.sck_out;
  assign sck_oe = s.sck_oe;

endmodule

// [logic/serial_unit_cfg.svh]
// Timing counts and field positions for the asynchronous serial unit.
`ifndef SERIAL_UNIT_CFG_SVH
`define SERIAL_UNIT_CFG_SVH

// Oversampling: sixteen ticks of the internal bit clock make one bit period.
`define SU_OVERSAMPLE 16
// Phase of the sixteen-tick bit at which the receiver samples (the eighth tick).
`define SU_SAMPLE_PHASE 4'h7
// Last phase of a bit; the transmitter changes the line after it.
`define SU_LAST_PHASE 4'hF
// Bit of the phase counter that drives the bit clock output, high from phase 8, giving a rising edge at bit centre.
`define SU_SCK_HIGH_BIT 3
// Index of the last data bit for eight-bit and seven-bit characters.
`define SU_LAST_BIT_8 3'h7
`define SU_LAST_BIT_7 3'h6
// Default width of the baud divisor.
`define SU_DIV_WIDTH 8

`endif

// [logic/serial_unit_pkg.sv]
// Types shared by the asynchronous serial unit.
package serial_unit_pkg;

  typedef enum logic [4:0] {
    TX_IDLE  = 5'h01,
    TX_START = 5'h02,
    TX_DATA  = 5'h04,
    TX_EXTRA = 5'h08,
    TX_STOP  = 5'h10
  } tx_state_e;

  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_EXTRA = 5'h08,
    RX_STOP  = 5'h10
  } rx_state_e;

endpackage

// [logic/bit_clock_gen.sv]
// Sixteen-times bit clock tick from the internal divisor or the external clock pin.
`timescale 1ns/100ps
`include "serial_unit_cfg.svh"

module bit_clock_gen #(
  parameter int DIV_W = `SU_DIV_WIDTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Configuration
  input wire logic ext_sel,
  input wire logic [DIV_W-1:0] baud_div_reg,
  // External clock pin
  input wire logic sck_in,
  // One-cycle tick at sixteen times the bit rate
  output logic tick
);

  initial begin
    if (DIV_W < 1 || DIV_W > 16) begin
      $error("bit_clock_gen: DIV_W must lie between 1 and 16");
    end
  end

  typedef struct packed {
    logic [DIV_W-1:0] div_cnt;
    logic sync1;
    logic sync2;
    logic prev;
    logic tick;
  } gen_s;

  gen_s s;
  gen_s next_s;

  // The divisor counts baud_div_reg + 1 reference cycles per tick; the mapping is a free choice.
  always_comb begin
    next_s = s;
    next_s.sync1 = sck_in;
    next_s.sync2 = s.sync1;
    next_s.prev = s.sync2;
    next_s.tick = 1'b0;
    if (ext_sel) begin
      next_s.div_cnt = '0;
      // The pin clock is assumed to run at sixteen times the bit rate.
      next_s.tick = s.sync2 && !s.prev;
    end else if (s.div_cnt >= baud_div_reg) begin
      next_s.div_cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.div_cnt = s.div_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule

// [verification/async_serial_comm_unit_chk.sv]
// Port-level assertions for the asynchronous serial unit.
`timescale 1ns/100ps

module async_serial_comm_unit_chk #(
  parameter int DIV_W = 8
) (
  // Clock, reset and settings
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [DIV_W-1:0] baud_div_reg,
  input wire logic clk_src_hi,
  input wire logic clk_src_lo,
  input wire logic tx_enable,
  input wire logic rx_enable,
  input wire logic tx_done_irq_enable,
  input wire logic rx_irq_enable,
  // Clear pulses
  input wire logic rx_full_clr,
  input wire logic parity_error_clr,
  input wire logic framing_error_clr,
  input wire logic overrun_clr,
  // Status and pins
  input wire logic tx_empty_flag,
  input wire logic tx_done_flag,
  input wire logic rx_full_flag,
  input wire logic parity_error_flag,
  input wire logic framing_error_flag,
  input wire logic overrun_flag,
  input wire logic [7:0] rx_holding_reg,
  input wire logic tx_done_irq,
  input wire logic rx_full_irq,
  input wire logic rx_err_irq,
  input wire logic tx_line,
  input wire logic sck_out,
  input wire logic sck_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  logic any_err;
  logic oe_want;
  logic any_clr;
  assign any_err = parity_error_flag | framing_error_flag | overrun_flag;
  assign oe_want = !clk_src_hi && clk_src_lo;
  assign any_clr = rx_full_clr | parity_error_clr | framing_error_clr | overrun_clr;

  // A low stretch on the line lasts a whole bit unless the transmitter is switched off.
  sequence s_low_bit;
    (!tx_line || !tx_enable)[*8] ##1 (!tx_line || !tx_enable)[*8];
  endsequence

  a_tx_off_idle: assert property (!tx_enable ##1 !tx_enable |-> tx_line && tx_empty_flag)
    else $error("transmitter not idle while disabled");
  a_rx_off_keep: assert property (!rx_enable && !any_clr |=> $stable({rx_full_flag, any_err, rx_holding_reg}))
    else $error("receive state changed while disabled");
  a_done_irq_level: assert property (tx_done_irq_enable && $past(tx_done_irq_enable) && $past(rstn)
    |-> tx_done_irq == tx_done_flag)
    else $error("transmit end request does not follow its flag");
  a_rx_irq_level: assert property (rx_irq_enable && $past(rx_irq_enable) && $past(rstn)
    |-> rx_full_irq == rx_full_flag && rx_err_irq == any_err)
    else $error("receive requests do not follow their flags");
  // A load inside a chain comes at the stop bit, so the start bit may follow up to two stop bits later.
  a_load_starts: assert property ($rose(tx_empty_flag) && $past(tx_enable) && tx_enable && !clk_src_hi
    && baud_div_reg == '0 |-> ##[0:40] (!tx_line || !tx_enable))
    else $error("load without start bit");
  a_bit_length: assert property ($fell(tx_line) && baud_div_reg == '0 && tx_enable |-> s_low_bit)
    else $error("low bit shorter than sixteen ticks");
  a_sck_oe_sel: assert property (rstn |=> sck_oe == $past(oe_want))
    else $error("clock output enable wrong");
  a_sck_centre: assert property ($changed(tx_line) && sck_oe && tx_enable && $past(tx_enable)
    |-> !sck_out && $past(sck_out))
    else $error("bit clock edge not at bit centre");
  a_done_at_stop: assert property ($rose(tx_done_flag) |-> tx_line)
    else $error("transmit end set off the stop bit");
  a_ovr_keeps: assert property ($rose(overrun_flag) |-> $stable(rx_holding_reg) && rx_full_flag)
    else $error("overrun replaced held data");
  a_err_halts: assert property (any_err && !rx_full_flag |=> !rx_full_flag)
    else $error("full flag set while an error stands");
endmodule

bind async_serial_comm_unit async_serial_comm_unit_chk #(.DIV_W(DIV_W)) i_chk (
  .ref_clk, .rstn, .baud_div_reg, .clk_src_hi, .clk_src_lo, .tx_enable, .rx_enable, .tx_done_irq_enable,
  .rx_irq_enable, .rx_full_clr, .parity_error_clr, .framing_error_clr, .overrun_clr, .tx_empty_flag,
  .tx_done_flag, .rx_full_flag, .parity_error_flag, .framing_error_flag, .overrun_flag, .rx_holding_reg,
  .tx_done_irq, .rx_full_irq, .rx_err_irq, .tx_line, .sck_out, .sck_oe
);

// [verification/serial_peer.sv]
// Far-side serial peer: drives the receive line and decodes the transmit line.
`timescale 1ns/100ps

module serial_peer (
  // Clock
  input wire logic ref_clk,
  // Serial lines
  input wire logic tx_line,
  output logic rx_line
);
  initial rx_line = 1'b1;

  // One bit lasts cpb cycles: sixteen ticks of one cycle at divisor zero, or of two on the external clock.
  int cpb = 16;

  task automatic put(input logic v);
    rx_line <= v;
    repeat (cpb) @(posedge ref_clk);
  endtask

  task automatic send(input logic [7:0] d, input int nb, input logic xen, input logic x, input logic sb);
    put(1'b0);
    for (int i = 0; i < nb; i++) put(d[i]);
    if (xen) put(x);
    put(sb);
    rx_line <= 1'b1;
    @(posedge ref_clk);
  endtask

  // Gives up after one bit and twenty-four cycles, so a late start shows as a failure.
  // The line is read on falling edges, where the registered output has settled.
  task automatic grab(input int nb, input logic xen, output logic [7:0] d, output logic x, output logic ok);
    int n;
    d = 8'h00;
    x = 1'b0;
    n = 0;
    while (tx_line !== 1'b0 && n < cpb + 24) begin
      @(negedge ref_clk);
      n++;
    end
    ok = (n < cpb + 24);
    repeat (cpb / 2) @(negedge ref_clk);
    for (int i = 0; i < nb; i++) begin
      repeat (cpb) @(negedge ref_clk);
      d[i] = tx_line;
    end
    if (xen) begin
      repeat (cpb) @(negedge ref_clk);
      x = tx_line;
    end
    repeat (cpb) @(negedge ref_clk);
    ok = ok && (tx_line === 1'b1);
    @(posedge ref_clk);
  endtask
endmodule

// [verification/test_async_serial_comm_unit.sv]
// Self-checking bench for the asynchronous serial unit.
`timescale 1ns/100ps

module test_async_serial_comm_unit;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic seven_bit, parity_enable, parity_odd_sel, multiproc_enable, two_stop;
  logic [7:0] baud_div_reg, tx_holding_wdata, rx_holding_reg, d1, d2;
  logic clk_src_hi, clk_src_lo, tx_enable, rx_enable, tx_empty_irq_enable, tx_done_irq_enable, rx_irq_enable;
  logic tx_holding_wr, multiproc_bit;
  logic sck_in = 1'b0;
  logic [4:0] clr;
  logic tx_empty_flag, tx_done_flag, rx_full_flag, parity_error_flag, framing_error_flag, overrun_flag;
  logic rx_multiproc_bit, tx_empty_irq, tx_done_irq, rx_full_irq, rx_err_irq, rx_line, tx_line, sck_out, sck_oe;
  int n_fail = 0;
  int n_checks = 0;
  int seed = 36697;

  async_serial_comm_unit i_dut (
    .ref_clk, .rstn, .seven_bit, .parity_enable, .parity_odd_sel, .multiproc_enable, .two_stop, .baud_div_reg,
    .clk_src_hi, .clk_src_lo, .tx_enable, .rx_enable, .tx_empty_irq_enable, .tx_done_irq_enable, .rx_irq_enable,
    .tx_holding_wr, .tx_holding_wdata, .multiproc_bit, .tx_empty_clr(clr[4]), .rx_full_clr(clr[3]),
    .parity_error_clr(clr[2]), .framing_error_clr(clr[1]), .overrun_clr(clr[0]), .tx_empty_flag, .tx_done_flag,
    .rx_full_flag, .parity_error_flag, .framing_error_flag, .overrun_flag, .rx_holding_reg, .rx_multiproc_bit,
    .tx_empty_irq, .tx_done_irq, .rx_full_irq, .rx_err_irq, .rx_line, .tx_line, .sck_in, .sck_out, .sck_oe
  );
  serial_peer i_peer (.ref_clk, .tx_line, .rx_line);

  always #50 ref_clk = ~ref_clk;

  // The far side gives sixteen clock periods per bit when the external source is selected.
  always @(posedge ref_clk) sck_in <= clk_src_hi ? ~sck_in : 1'b0;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks=%0d failures=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  function automatic int nbits();
    return seven_bit ? 7 : 8;
  endfunction
  function automatic logic xen();
    return parity_enable | multiproc_enable;
  endfunction
  function automatic logic [7:0] dmask(input logic [7:0] d);
    return seven_bit ? {1'b0, d[6:0]} : d;
  endfunction
  // Even parity makes the total count of ones even, so the bit is the XOR of the data.
  function automatic logic ext_bit(input logic [7:0] d, input logic mp);
    return multiproc_enable ? mp : ((^dmask(d)) ^ parity_odd_sel);
  endfunction

  task automatic pulse(input logic [4:0] m);
    clr <= m;
    @(posedge ref_clk);
    clr <= 5'h00;
  endtask

  task automatic set_fmt(input logic [5:0] f);
    tx_enable <= 1'b0;
    rx_enable <= 1'b0;
    @(posedge ref_clk);
    {clk_src_hi, seven_bit, parity_enable, parity_odd_sel, two_stop, multiproc_enable} <= f;
    clk_src_lo <= 1'($random(seed));
    {tx_empty_irq_enable, tx_done_irq_enable, rx_irq_enable} <= 3'($random(seed));
    repeat (i_peer.cpb) @(posedge ref_clk);
    tx_enable <= 1'b1;
    rx_enable <= 1'b1;
    @(posedge ref_clk);
  endtask

  task automatic send_tx(input logic [7:0] d, input logic mp);
    int n;
    tx_holding_wdata <= d;
    multiproc_bit <= mp;
    tx_holding_wr <= 1'b1;
    @(posedge ref_clk);
    tx_holding_wr <= 1'b0;
    pulse(5'h10);
    // A chained load waits for the stop bit of the frame on the line, up to ten bits.
    n = 0;
    @(negedge ref_clk);
    while (tx_empty_flag !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 400) begin
      n_fail++;
      conclude();
    end
    chk(tx_empty_irq, tx_empty_irq_enable);
    @(posedge ref_clk);
  endtask

  task automatic grab_chk(input logic [7:0] d, input logic mp);
    logic [7:0] got;
    logic x, ok;
    i_peer.grab(nbits(), xen(), got, x, ok);
    chk(got, dmask(d));
    if (xen()) chk(x, ext_bit(d, mp));
    chk(ok, 1'b1);
    if (!ok) conclude();
  endtask

  task automatic rx_case(input logic [7:0] d, input logic mp, input logic bp, input logic bs);
    logic perr;
    perr = bp && parity_enable && !multiproc_enable;
    i_peer.send(d, nbits(), xen(), ext_bit(d, mp) ^ bp, !bs);
    chk(rx_holding_reg, dmask(d));
    chk({rx_full_flag, parity_error_flag, framing_error_flag}, {!(perr || bs), perr, bs});
    if (multiproc_enable) chk(rx_multiproc_bit, mp);
    pulse(5'h0F);
  endtask

  initial begin
    {seven_bit, parity_enable, parity_odd_sel, multiproc_enable, two_stop} = 5'h00;
    {clk_src_hi, tx_enable, rx_enable, tx_holding_wr, multiproc_bit} = 5'h00;
    {clk_src_lo, tx_empty_irq_enable, tx_done_irq_enable, rx_irq_enable} = 4'hF;
    baud_div_reg = 8'h00; // Tick every cycle keeps one bit at sixteen cycles.
    tx_holding_wdata = 8'h00;
    clr = 5'h00;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({tx_line, tx_empty_flag, tx_done_flag, rx_full_flag, sck_oe}, 5'h1C);
    @(posedge ref_clk);
    rstn <= 1'b1;
    for (int f = 0; f < 32; f++) begin
      set_fmt(6'(f));
      d1 = 8'($random(seed));
      multiproc_bit <= 1'($random(seed));
      @(posedge ref_clk);
      fork
        send_tx(d1, multiproc_bit);
        grab_chk(d1, multiproc_bit);
      join
      chk(tx_done_flag, 1'b1);
      rx_case(8'($random(seed)), 1'($random(seed)), 1'b0, 1'b0);
    end
    // External clock at sixteen periods per bit stretches every bit to thirty-two cycles.
    i_peer.cpb = 32;
    set_fmt(6'h25);
    d1 = 8'($random(seed));
    fork
      send_tx(d1, 1'b1);
      grab_chk(d1, 1'b1);
    join
    rx_case(8'($random(seed)), 1'b0, 1'b0, 1'b0);
    i_peer.cpb = 16;
    set_fmt(6'h08);
    rx_case(8'($random(seed)), 1'b0, 1'b1, 1'b0);
    rx_case(8'($random(seed)), 1'b0, 1'b0, 1'b1);
    d1 = 8'($random(seed));
    d2 = ~d1;
    i_peer.send(d1, 8, 1'b1, ext_bit(d1, 1'b0), 1'b1);
    i_peer.send(d2, 8, 1'b1, ext_bit(d2, 1'b0), 1'b1);
    chk({overrun_flag, rx_full_flag, rx_holding_reg}, {2'h3, d1});
    i_peer.send(d2, 8, 1'b1, ext_bit(d2, 1'b0), 1'b1);
    rx_enable <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk({overrun_flag, rx_full_flag, rx_holding_reg}, {2'h3, d1});
    pulse(5'h0F);
    rx_enable <= 1'b1;
    fork
      begin
        send_tx(d1, 1'b0);
        send_tx(d2, 1'b0);
      end
      begin
        grab_chk(d1, 1'b0);
        chk(tx_done_flag, 1'b0);
        grab_chk(d2, 1'b0);
      end
    join
    send_tx(d1, 1'b0);
    repeat (40) @(posedge ref_clk);
    tx_enable <= 1'b0;
    repeat (2) @(posedge ref_clk);
    // A disabled transmitter marks high, so a break has to come from the port output.
    chk({tx_line, tx_empty_flag}, 2'h3);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({tx_line, tx_empty_flag, tx_done_flag, rx_full_flag, sck_oe}, 5'h1C);
    @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    conclude();
  end

  initial begin
    repeat (100000) @(posedge ref_clk);
    n_fail++;
    conclude();
  end
endmodule
